// File: hw/lcdc_pkg.sv
// Purpose: shared constants and types for the lcd ram addressing and control block
// Assumes: 50 MHz reference clock, eighteen-common geometry as the widest case
// Notes: register numbers are the 4-bit codes carried in the serial command byte
`default_nettype none
package lcdc_pkg;
    // register numbers
    localparam logic [3:0] REG_KEY_SCAN = 4'h0;
    localparam logic [3:0] REG_PANEL_ENABLE_DATA = 4'h1;
    localparam logic [3:0] REG_COLUMN_PTR = 4'h2;
    localparam logic [3:0] REG_ROW_PTR = 4'h3;
    localparam logic [3:0] REG_PORT_A = 4'h4;
    localparam logic [3:0] REG_PORT_B = 4'h5;
    localparam logic [3:0] REG_CONTROL_ONE = 4'h8;
    localparam logic [3:0] REG_CONTROL_TWO = 4'h9;
    // serial command byte: read flag position
    localparam int CMD_READ_BIT = 7;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    // control one field positions
    localparam int C1_INC_BIT = 7;
    localparam int C1_WLS_BIT = 6;
    localparam int C1_KT_BIT = 5;
    localparam int C1_SHL_BIT = 4;
    localparam int C1_DUTY_LSB = 0;
    // control two field positions and reset value
    localparam int C2_PANEL_BIT = 0;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    // geometry
    localparam int COLS = 80;
    localparam int COMS = 18;
    localparam int KEY_ROWS = 5;
    localparam logic [3:0] X_MAX_8 = 4'h9;
    localparam logic [3:0] X_MAX_6 = 4'hD;
    localparam logic [2:0] KEY_ROW_LAST = 3'h4;
    localparam logic [1:0] REQ_AFTER_CYCLES = 2'h2;
    // timing
    localparam int CLK_KHZ = 50000;
    localparam int SCAN_SHORT_MS = 5;
    localparam int SCAN_LONG_MS = 10;
    localparam int SCAN_SHORT_CYC = SCAN_SHORT_MS * CLK_KHZ;
    localparam int SCAN_LONG_CYC = SCAN_LONG_MS * CLK_KHZ;
    localparam int LINE_TIME_US = 250;
    localparam int LINE_CYC = LINE_TIME_US * CLK_KHZ / 1000;
    // key scanner states
    typedef enum logic {KS_IDLE, KS_SCAN} lcdc_scan_t;
endpackage
`default_nettype wire

// File: hw/lcdc_core.sv
// Purpose: register bank, display ram, address counters, key scanner and panel scan
// Assumes: serial frames of 16 bits, command byte then data byte, msb first on rising serial_clk
// Notes: a read frame returns the answer to the previous read command in its data phase
`timescale 1ns/10ps
`default_nettype none
module lcdc_core #(
    parameter bit TEN_COMMON = 1'b0,
    parameter int SCAN_SHORT_CYCLES = lcdc_pkg::SCAN_SHORT_CYC,
    parameter int SCAN_LONG_CYCLES = lcdc_pkg::SCAN_LONG_CYC,
    parameter int LINE_CYCLES = lcdc_pkg::LINE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic serial_clk,
    input wire logic serial_cs_n,
    input wire logic serial_data_io_in,
    output logic serial_data_io_out,
    output logic serial_data_io_oe,
    output logic key_request,
    output logic [lcdc_pkg::KEY_ROWS-1:0] key_row_drive_n,
    input wire logic [lcdc_pkg::KEY_ROWS-1:0] key_column_sense_n,
    output logic [lcdc_pkg::COLS-1:0] pixel_line_drive,
    output logic [lcdc_pkg::COMS-1:0] backplane_drive,
    output logic port_a_output,
    output logic port_a_oe,
    output logic [7:0] port_b_outputs,
    output logic port_b_oe
);
    import lcdc_pkg::*;

    localparam logic [19:0] SLOT_SHORT = 20'(SCAN_SHORT_CYCLES / KEY_ROWS - 1);
    localparam logic [19:0] SLOT_LONG = 20'(SCAN_LONG_CYCLES / KEY_ROWS - 1);
    localparam logic [19:0] LINE_LAST = 20'(LINE_CYCLES - 1);

    // duty field to number of display lines
    function automatic logic [4:0] duty_lines(input logic [1:0] sel, input logic ten);
        logic [4:0] base;
        base = ten ? 5'h08 : 5'h10;
        duty_lines = (sel == 2'h0) ? base : (sel == 2'h1) ? base + 5'h01 : base + 5'h02;
    endfunction

    // link domain: frame shifter and read-back driver
    logic [4:0] bit_cnt_q;
    logic [14:0] shift_in_q;
    logic frame_rd_q;
    logic [6:0] shift_out_q;
    logic sdo_q;
    logic sdo_oe_q;
    logic [15:0] link_word_q;
    logic link_tog_q;
    logic [7:0] rd_hold_q;

    // chip select high ends the frame and releases the data pin at once
    always_ff @(posedge serial_clk or negedge arst_n or posedge serial_cs_n)
    begin
        if (!arst_n || serial_cs_n)
        begin
            bit_cnt_q <= 5'h00;
            shift_in_q <= 15'h0000;
            frame_rd_q <= 1'b0;
            shift_out_q <= 7'h00;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else
        begin
            if (bit_cnt_q != FRAME_BITS)
            begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                shift_in_q <= {shift_in_q[13:0], serial_data_io_in};
            end
            if (bit_cnt_q == 5'h00)
            begin
                frame_rd_q <= serial_data_io_in;
            end
            if (bit_cnt_q == CMD_LAST_BIT && frame_rd_q)
            begin
                sdo_oe_q <= 1'b1;
                sdo_q <= rd_hold_q[7];
                shift_out_q <= rd_hold_q[6:0];
            end
            else if (sdo_oe_q)
            begin
                sdo_q <= shift_out_q[6];
                shift_out_q <= {shift_out_q[5:0], 1'b0};
            end
        end
    end

    // completed frame is held and announced by a toggle
    always_ff @(posedge serial_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_word_q <= 16'h0000;
            link_tog_q <= 1'b0;
        end
        else if (!serial_cs_n && bit_cnt_q == FRAME_BITS - 5'h01)
        begin
            link_word_q <= {shift_in_q, serial_data_io_in};
            link_tog_q <= ~link_tog_q;
        end
    end

    // core domain: toggle synchroniser and column sense synchroniser
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic [4:0] col_s1_q, col_s2_q, col_s3_q, col_q;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            col_s1_q <= 5'h1F;
            col_s2_q <= 5'h1F;
            col_s3_q <= 5'h1F;
            col_q <= 5'h1F;
        end
        else
        begin
            tog_s1_q <= link_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            col_s1_q <= key_column_sense_n;
            col_s2_q <= col_s1_q;
            col_s3_q <= col_s2_q;
            col_q <= (col_q & (col_s2_q ^ col_s3_q)) | (col_s2_q & ~(col_s2_q ^ col_s3_q));
        end
    end

    // request decode
    wire req = tog_s2_q ^ tog_s3_q;
    wire is_rd = link_word_q[8 + CMD_READ_BIT];
    wire [3:0] regn = link_word_q[11:8];
    wire [7:0] wdat = link_word_q[7:0];
    wire wr_en = req && !is_rd;
    wire data_acc = req && regn == REG_PANEL_ENABLE_DATA;
    wire [4:0] closed = ~col_q;

    // control one holds no reset: it survives the reset pin
    logic inc_q, wls_q, kt_q, shl_q;
    logic [1:0] duty_q;
    always_ff @(posedge ref_clk)
    begin
        if (wr_en && regn == REG_CONTROL_ONE)
        begin
            inc_q <= wdat[C1_INC_BIT];
            wls_q <= wdat[C1_WLS_BIT];
            kt_q <= wdat[C1_KT_BIT];
            shl_q <= wdat[C1_SHL_BIT];
            duty_q <= wdat[C1_DUTY_LSB +: 2];
        end
    end

    // counter limits and next values
    wire [4:0] lines = duty_lines(duty_q, TEN_COMMON);
    logic [3:0] x_q;
    logic [4:0] y_q;
    wire [3:0] x_max = wls_q ? X_MAX_6 : X_MAX_8;
    wire [4:0] y_max = lines - 5'h01;
    wire x_at = x_q == x_max;
    wire y_at = y_q == y_max;
    wire [3:0] x_nxt = x_at ? 4'h0 : x_q + 4'h1;
    wire [4:0] y_nxt = y_at ? 5'h00 : y_q + 5'h01;

    // display ram word placement
    logic [COLS-1:0] ram_q [COMS];
    wire [6:0] col_base = wls_q ? 7'({3'h0, x_q} * 7'h06) : {x_q, 3'h0};
    wire [7:0] wr_word = wls_q ? {wdat[5:0], 2'h0} : wdat;
    wire [3:0] wr_len = wls_q ? 4'h6 : 4'h8;
    wire row_ok = y_q < 5'(COMS);
    logic [7:0] rd_bits;
    always_comb
    begin
        rd_bits = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (row_ok && 32'(col_base) + i < COLS)
            begin
                rd_bits[7 - i] = ram_q[y_q[4:0]][7'(col_base + 7'(i))];
            end
        end
    end
    wire [7:0] ram_rd = wls_q ? {2'h0, rd_bits[7:2]} : rd_bits;

    // ram keeps no reset so contents survive reset and display off
    always_ff @(posedge ref_clk)
    begin
        if (wr_en && regn == REG_PANEL_ENABLE_DATA && row_ok)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (i < wr_len && 32'(col_base) + i < COLS)
                begin
                    ram_q[y_q[4:0]][7'(col_base + 7'(i))] <= wr_word[7 - i];
                end
            end
        end
    end

    // read data selection
    logic [7:0] rd_val;
    logic [2:0] st_q;
    logic [4:0] key_data_q [KEY_ROWS];
    logic [7:0] ctl2_q;
    logic port_a_q, port_a_oe_q, port_b_oe_q;
    logic [7:0] port_b_q;
    always_comb
    begin
        if (regn == REG_KEY_SCAN)
            rd_val = {st_q, (st_q <= KEY_ROW_LAST) ? key_data_q[st_q] : 5'h00};
        else if (regn == REG_PANEL_ENABLE_DATA)
            rd_val = ram_rd;
        else if (regn == REG_COLUMN_PTR)
            rd_val = {4'h0, x_q};
        else if (regn == REG_ROW_PTR)
            rd_val = {3'h0, y_q};
        else if (regn == REG_PORT_A)
            rd_val = {7'h00, port_a_q};
        else if (regn == REG_PORT_B)
            rd_val = port_b_q;
        else if (regn == REG_CONTROL_ONE)
            rd_val = {inc_q, wls_q, kt_q, shl_q, 2'h0, duty_q};
        else if (regn == REG_CONTROL_TWO)
            rd_val = ctl2_q;
        else
            rd_val = 8'h00;
    end

    // register bank with resettable state and access side effects
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            x_q <= 4'h0;
            y_q <= 5'h00;
            st_q <= 3'h0;
            ctl2_q <= CONTROL_TWO_RST;
            port_a_q <= 1'b0;
            port_a_oe_q <= 1'b0;
            port_b_q <= 8'h00;
            port_b_oe_q <= 1'b0;
            rd_hold_q <= 8'h00;
        end
        else if (req)
        begin
            if (is_rd)
                rd_hold_q <= rd_val;
            if (is_rd && regn == REG_KEY_SCAN)
                st_q <= (st_q == KEY_ROW_LAST) ? 3'h0 : st_q + 3'h1;
            if (data_acc && inc_q)
            begin
                x_q <= x_nxt;
                if (x_at)
                    y_q <= y_nxt;
            end
            else if (data_acc)
            begin
                y_q <= y_nxt;
                if (y_at)
                    x_q <= x_nxt;
            end
            else if (wr_en && regn == REG_COLUMN_PTR)
                x_q <= wdat[3:0];
            else if (wr_en && regn == REG_ROW_PTR)
                y_q <= wdat[4:0];
            else if (wr_en && regn == REG_PORT_A)
            begin
                port_a_q <= wdat[0];
                port_a_oe_q <= 1'b1;
            end
            else if (wr_en && regn == REG_PORT_B)
            begin
                port_b_q <= wdat;
                port_b_oe_q <= 1'b1;
            end
            else if (wr_en && regn == REG_CONTROL_TWO)
                ctl2_q <= wdat;
        end
    end

    // key scanner: idle until a column closes, then row by row
    lcdc_scan_t ks_q;
    logic [2:0] row_q;
    logic [19:0] slot_q;
    logic [1:0] cyc_q;
    logic hit_q, key_req_q;
    logic [4:0] row_drv_q;
    wire [19:0] slot_last = kt_q ? SLOT_LONG : SLOT_SHORT;
    wire cyc_hit = hit_q || (|closed);
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ks_q <= KS_IDLE;
            row_q <= 3'h0;
            slot_q <= 20'h00000;
            cyc_q <= 2'h0;
            hit_q <= 1'b0;
            key_req_q <= 1'b0;
            row_drv_q <= 5'h00;
            for (int r = 0; r < KEY_ROWS; r++)
                key_data_q[r] <= 5'h00;
        end
        else
        begin
            case (ks_q)
                KS_IDLE:
                begin
                    if (|closed)
                    begin
                        ks_q <= KS_SCAN;
                        row_q <= 3'h0;
                        slot_q <= 20'h00000;
                        cyc_q <= 2'h0;
                        hit_q <= 1'b0;
                        row_drv_q <= 5'h1E;
                    end
                end
                default:
                begin
                    slot_q <= slot_q + 20'h00001;
                    if (slot_q == slot_last)
                    begin
                        slot_q <= 20'h00000;
                        key_data_q[row_q] <= closed;
                        hit_q <= cyc_hit;
                        if (row_q == KEY_ROW_LAST && !cyc_hit)
                        begin
                            ks_q <= KS_IDLE;
                            key_req_q <= 1'b0;
                            row_drv_q <= 5'h00;
                        end
                        else if (row_q == KEY_ROW_LAST)
                        begin
                            row_q <= 3'h0;
                            hit_q <= 1'b0;
                            row_drv_q <= 5'h1E;
                            if (cyc_q != REQ_AFTER_CYCLES)
                                cyc_q <= cyc_q + 2'h1;
                            if (cyc_q + 2'h1 == REQ_AFTER_CYCLES)
                                key_req_q <= 1'b1;
                        end
                        else
                        begin
                            row_q <= row_q + 3'h1;
                            row_drv_q <= ~(5'h01 << (row_q + 3'h1));
                        end
                    end
                end
            endcase
        end
    end

    // panel scan: one common selected per line period
    logic [19:0] line_q;
    logic [4:0] com_q;
    logic [COLS-1:0] pix_q;
    logic [COMS-1:0] bp_q;
    wire panel_on = ctl2_q[C2_PANEL_BIT];
    wire [4:0] phys = shl_q ? lines - 5'h01 - com_q : com_q;
    wire [COMS-1:0] bp_d;
    generate
        for (genvar c = 0; c < COMS; c++)
        begin : g_com
            assign bp_d[c] = panel_on && phys == 5'(c);
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_q <= 20'h00000;
            com_q <= 5'h00;
            pix_q <= '0;
            bp_q <= '0;
        end
        else
        begin
            line_q <= (line_q == LINE_LAST) ? 20'h00000 : line_q + 20'h00001;
            if (line_q == LINE_LAST)
                com_q <= (!panel_on || com_q >= lines - 5'h01) ? 5'h00 : com_q + 5'h01; // parked while off, duty may be unset
            pix_q <= panel_on ? ram_q[phys] : '0;
            bp_q <= bp_d;
        end
    end

    // outputs straight from flip-flops; the oscillator is ref_clk itself and runs through reset
    assign serial_data_io_out = sdo_q;
    assign serial_data_io_oe = sdo_oe_q;
    assign key_request = key_req_q;
    assign key_row_drive_n = row_drv_q;
    assign pixel_line_drive = pix_q;
    assign backplane_drive = bp_q;
    assign port_a_output = port_a_q;
    assign port_a_oe = port_a_oe_q;
    assign port_b_outputs = port_b_q;
    assign port_b_oe = port_b_oe_q;

    // checks
    panel_off_dark_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !panel_on |=> (bp_q == '0) && (pix_q == '0)) else $error("panel off but drive active");
    ram_kept_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(panel_on) |-> $stable(ram_q[0][15:8])) else $error("ram changed when panel turned off");
    x_wrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        data_acc && inc_q && x_at && !y_at |=> x_q == 4'h0 && y_q == $past(y_q) + 5'h01) else $error("x wrap wrong");
    y_wrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        data_acc && !inc_q && y_at && !x_at |=> y_q == 5'h00 && x_q == $past(x_q) + 4'h1) else $error("y wrap wrong");
    step_after_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        data_acc && !x_at && !y_at |=> (x_q != $past(x_q)) != (y_q != $past(y_q))) else $error("no single step");
    duty_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        duty_q[1] |-> lines == (TEN_COMMON ? 5'h0A : 5'h12)) else $error("duty decode wrong");
    short_word_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req && is_rd && regn == REG_PANEL_ENABLE_DATA && wls_q |=> rd_hold_q[7:6] == 2'h0) else $error("high bits read");
    req_rise_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(key_req_q) |-> $past(ks_q) == KS_SCAN && $past(row_q) == KEY_ROW_LAST && $past(cyc_q) == 2'h1)
        else $error("request rose off schedule");
    req_drop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ks_q == KS_IDLE |-> !key_req_q) else $error("request high while idle");
endmodule
`default_nettype wire

// File: hw/lcdc_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: testbench/lcdc_host.sv
// Purpose: host model on the serial register link
// Assumes: 16-bit frames, msb first, taken on rising serial_clk
// Notes: serial_clk stands still between frames
`timescale 1ns/10ps
`default_nettype none
module lcdc_host (
    output logic serial_clk,
    output logic serial_cs_n,
    output logic host_d,
    output logic host_oe,
    input wire logic data_pin
);
    initial
    begin
        serial_clk = 1'b0;
        serial_cs_n = 1'b1;
        host_d = 1'b0;
        host_oe = 1'b0;
    end
    // one frame; the host lets go of the pin for the data phase of a read
    task automatic frame(input logic [15:0] w, output logic [7:0] rd);
        serial_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            host_oe = !(w[15] && i < 8);
            host_d = w[i];
            #7.5;
            rd[i % 8] = data_pin; // low half overwrites the command-phase bits
            serial_clk = 1'b1;
            #7.5;
            serial_clk = 1'b0;
        end
        #7.5;
        serial_cs_n = 1'b1;
        host_oe = 1'b0;
        #200; // frame gap lets the core finish the request
    endtask
endmodule
`default_nettype wire

// File: testbench/test_lcd_ram_addressing_control.sv
// Purpose: self-checking bench for lcdc_core
// Assumes: host model on the link, one key at row 2 column 0
// Notes: shortened scan and line counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
module test_lcd_ram_addressing_control;
    import lcdc_pkg::*;
    logic ref_clk;
    logic arst_n;
    logic press;
    logic [7:0] v;
    int error_cnt;
    int n_tests;
    wire logic serial_clk, serial_cs_n, host_d, host_oe, dev_out, dev_oe, data_pin, key_request;
    wire logic port_a_output, port_a_oe, port_b_oe;
    wire logic [4:0] rows_n;
    wire logic [4:0] sense_n;
    wire logic [7:0] port_b_outputs;
    wire logic [COLS-1:0] pix;
    wire logic [COMS-1:0] bp;
    // device wins the pin; a released pin shows the inverse of the host's last bit
    assign data_pin = dev_oe ? dev_out : (host_oe ? host_d : ~host_d);
    assign sense_n = {4'hF, rows_n[2] | ~press};
    lcdc_host host (.serial_clk(serial_clk), .serial_cs_n(serial_cs_n), .host_d(host_d),
        .host_oe(host_oe), .data_pin(data_pin));
    lcdc_core #(.TEN_COMMON(1'b0), .SCAN_SHORT_CYCLES(50), .SCAN_LONG_CYCLES(100), .LINE_CYCLES(8)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .serial_clk(serial_clk), .serial_cs_n(serial_cs_n),
        .serial_data_io_in(data_pin), .serial_data_io_out(dev_out), .serial_data_io_oe(dev_oe),
        .key_request(key_request), .key_row_drive_n(rows_n), .key_column_sense_n(sense_n),
        .pixel_line_drive(pix), .backplane_drive(bp), .port_a_output(port_a_output),
        .port_a_oe(port_a_oe), .port_b_outputs(port_b_outputs), .port_b_oe(port_b_oe));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] r, input logic [7:0] d);
        logic [7:0] x;
        host.frame({4'h0, r, d}, x);
    endtask
    // read command, then an unmapped read fetches the answer
    task automatic rdchk(input logic [3:0] r, input logic [7:0] e);
        host.frame({4'h8, r, 8'h00}, v);
        host.frame(16'h8F00, v);
        check(v, e);
    endtask
    task automatic wait_req(input logic lvl);
        int n;
        for (n = 0; n < 300 && key_request !== lvl; n++)
            @(negedge ref_clk);
        if (n == 300)
        begin
            error_cnt++;
            close_out();
        end
    endtask
    // x-direction counting with 8-bit and 6-bit words
    task automatic t_xinc();
        wr(REG_CONTROL_ONE, 8'h80);
        wr(REG_COLUMN_PTR, 8'h09);
        wr(REG_ROW_PTR, 8'h02);
        wr(REG_PANEL_ENABLE_DATA, 8'hC3);
        rdchk(REG_COLUMN_PTR, 8'h00);
        rdchk(REG_ROW_PTR, 8'h03);
        wr(REG_COLUMN_PTR, 8'h09);
        wr(REG_ROW_PTR, 8'h02);
        rdchk(REG_PANEL_ENABLE_DATA, 8'hC3);
        rdchk(REG_COLUMN_PTR, 8'h00);
        wr(REG_CONTROL_ONE, 8'hC0);
        wr(REG_COLUMN_PTR, 8'h0D);
        wr(REG_ROW_PTR, 8'h00);
        wr(REG_PANEL_ENABLE_DATA, 8'hFF);
        rdchk(REG_COLUMN_PTR, 8'h00);
        rdchk(REG_ROW_PTR, 8'h01);
        wr(REG_COLUMN_PTR, 8'h0D);
        wr(REG_ROW_PTR, 8'h00);
        rdchk(REG_PANEL_ENABLE_DATA, 8'h30);
    endtask
    // y-direction wrap for every duty code
    task automatic t_yinc();
        for (int d = 0; d < 4; d++)
        begin
            wr(REG_CONTROL_ONE, 8'(d));
            wr(REG_COLUMN_PTR, 8'h03);
            wr(REG_ROW_PTR, (d == 0) ? 8'h0F : (d == 1) ? 8'h10 : 8'h11);
            wr(REG_PANEL_ENABLE_DATA, 8'h00);
            rdchk(REG_ROW_PTR, 8'h00);
            rdchk(REG_COLUMN_PTR, 8'h04);
        end
    endtask
    // panel on shows the word on row 0, off blanks pins and keeps ram
    task automatic t_panel();
        int n;
        wr(REG_CONTROL_ONE, 8'h00);
        wr(REG_COLUMN_PTR, 8'h01);
        wr(REG_ROW_PTR, 8'h00);
        wr(REG_PANEL_ENABLE_DATA, 8'hC1);
        wr(REG_CONTROL_TWO, 8'h01);
        for (n = 0; n < 400 && bp !== 18'h00001; n++)
        begin
            @(negedge ref_clk);
            check(bp[17:16], 2'h0);
        end
        check(n < 400, 1'b1);
        for (n = 0; n < 8; n++)
            v[7 - n] = pix[8 + n];
        check(v, 8'hC1);
        wr(REG_CONTROL_TWO, 8'h00);
        check(bp, '0);
        check(pix, '0);
        wr(REG_COLUMN_PTR, 8'h01);
        wr(REG_ROW_PTR, 8'h00);
        rdchk(REG_PANEL_ENABLE_DATA, 8'hC1);
    endtask
    // key press raises the flag after two scan cycles, release drops it
    task automatic t_key();
        press = 1'b1;
        repeat (40) @(negedge ref_clk);
        check(key_request, 1'b0);
        wait_req(1'b1);
        rdchk(REG_KEY_SCAN, 8'h00);
        rdchk(REG_KEY_SCAN, 8'h20);
        rdchk(REG_KEY_SCAN, 8'h41);
        check($countones(v[4:0]) < 3, 1'b1);
        press = 1'b0;
        wait_req(1'b0);
    endtask
    // reset in mid-run with ports driven and the flag up
    task automatic t_rst2();
        wr(REG_CONTROL_ONE, 8'h93);
        wr(REG_PORT_A, 8'h01);
        wr(REG_PORT_B, 8'h5A);
        check({port_a_oe, port_a_output, port_b_oe, port_b_outputs}, 11'h75A);
        press = 1'b1;
        wait_req(1'b1);
        @(negedge ref_clk);
        arst_n = 1'b0;
        #1;
        check({key_request, port_a_oe, port_b_oe, rows_n, bp}, '0);
        press = 1'b0;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        rdchk(REG_CONTROL_ONE, 8'h93);
        rdchk(REG_CONTROL_TWO, CONTROL_TWO_RST);
        rdchk(REG_COLUMN_PTR, 8'h00);
        rdchk(REG_ROW_PTR, 8'h00);
    endtask
    initial
    begin
        error_cnt = 0;
        n_tests = 0;
        arst_n = 1'b0;
        press = 1'b0;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({key_request, rows_n, port_a_oe, port_b_oe, bp}, '0);
        check(pix, '0);
        rdchk(REG_CONTROL_TWO, CONTROL_TWO_RST);
        t_xinc();
        t_yinc();
        t_panel();
        t_key();
        t_rst2();
        close_out();
    end
endmodule
`default_nettype wire
